// File: verilog/ext_ctrl_map.vh
// register indices, field positions and reset values of the extension control bank
`ifndef EXT_CTRL_MAP_VH
`define EXT_CTRL_MAP_VH
`define IDX_EMU_MODE      7'h14
`define IDX_WR_PROTECT    7'h15
`define IDX_TRAP_ENABLE   7'h16
`define IDX_TRAP_STATUS   7'h17
`define IDX_ALT_HDISP_END 7'h18
`define IDX_ALT_HSYNC_ST  7'h19
`define IDX_ALT_HSYNC_END 7'h1A
`define IDX_ALT_HTOTAL    7'h1B
`define IDX_ALT_HBLANK_ST 7'h1C
`define IDX_ALT_HBLANK_END 7'h1D
`define IDX_ALT_ROW_OFS   7'h1E
`define IDX_SLIDE_CTRL    7'h20
`define IDX_HOLD_PLANE0   7'h21
`define IDX_HOLD_PLANE1   7'h22
`define IDX_HOLD_PLANE2   7'h23
`define IDX_HOLD_PLANE3   7'h24
`define IDX_FORCE_LEVELS  7'h27
// writable masks; reserved bits read zero
`define EMU_WR_MASK       8'hF3
`define PROT_WR_MASK      8'h7F
`define TRAP_WR_MASK      8'h3F
`define SLIDE_WR_MASK     8'h03
`define FORCE_WR_MASK     8'h3F
`define REG_RESET         8'h00
// emulation mode codes
`define EMU_STD           2'h0
`define EMU_COLOR_GFX     2'h1
`define EMU_MONO          2'h2
`define EMU_MONO_GFX      2'h3
// emulation control field positions
`define EMU_DE_MODE_BIT   4
`define EMU_VR_MODE_BIT   5
`define EMU_VS_MODE_BIT   6
`define EMU_IRQ_FN_BIT    7
// protect group bits
`define PROT_STD_GRP      0
`define PROT_CURSOR_GRP   1
`define PROT_SPLIT_GRP    2
`define PROT_VTIME_GRP    3
`define PROT_MISC_GRP     4
`define PROT_PAL_GRP      5
`define PROT_TIMING0_GRP  6
// trap groups
`define TRAP_GROUPS       6
`define TRAP_TIMING_BIT   5
// timing controller indices for trap group 5
`define CRTC_LAST_LOW     5'h0B
`define CRTC_FIRST_HIGH   5'h10
`define CRTC_LAST_HIGH    5'h18
// slide control bits and alternate blank end mode bit
`define SLIDE_EN_BIT      0
`define SLIDE_DIR_BIT     1
`define ALT_BLANK_MODE_BIT 7
`endif

// File: verilog/display_ext_control_regs.v
// extension control register bank of the display controller
// Functional notes
// - mode field picks standard/colour-gfx/mono/mono-gfx; bits 3-2 read back config port
// - status bit 0 shows display enable, or hsync when mode bit set
// - status bit 3 shows vertical retrace, or video level when mode bit set
// - status bit 7 shows vsync only when its mode bit is set
// - interrupt pin drive depends on function bit, bus type, enable and activity
// - protect bits 0 and 1 block standard group and cursor/char height writes
// - protect bits 2 and 3 block split-screen/mode and vertical timing writes
// - protect bit 4 blocks misc/feature; bit 5 kills palette strobes and state writes
// - protect bit 6 guards first eight timing registers except overflow bit 4, ORed
// - trap enables 0-5 raise trap output on matching accesses; cleared on reset
// - trapped accesses set sticky status bits; reading status clears them
// - status bit 5 covers timing indices 00-0B and 10-18
// - low-res colour-gfx and mono-gfx modes use alternate horizontal registers
// - alternate blank end bit 7 selects enhanced split-screen behaviour
// - alternate sync end bit 7 is blank end bit 5; bits 6-5 sync delay
// - slide mode shifts write data and merges previous carry-over
// - direction bit: left at 0, right at 1, only while slide enabled
// - four per-plane hold registers keep carry-over: plane 0 of mode 0, 2 and 3 writes, planes 1-3 of mode 1 writes
// - write modes 0, 2 and 3 use plane 0 hold; mode 1 uses each plane's own hold
// - force register bits 0-5 hold forced display enable/blank/sync levels
`timescale 1ns/1ps
`include "ext_ctrl_map.vh"
module display_ext_control_regs (
  input  wire        CORE_CLK_I,
  input  wire        RESET_I,
  // indexed extension port, same clock
  input  wire [6:0]  EXT_INDEX_I,
  input  wire        EXT_WR_I,
  input  wire        EXT_RD_I,
  input  wire [7:0]  EXT_WDATA_I,
  output reg  [7:0]  EXT_RDATA_O,
  // observed standard accesses, same clock
  input  wire        IO_ACCESS_I,
  input  wire [9:0]  IO_ADDR_I,
  input  wire        CRTC_ACCESS_I,
  input  wire [4:0]  CRTC_INDEX_I,
  input  wire        PAL_RD_REQ_I,
  input  wire        PAL_WR_REQ_I,
  input  wire        CRTC_PROTECT_I,
  input  wire [1:0]  MONO_CFG_I,
  // status sources, asynchronous to the core
  input  wire        DISP_EN_I,
  input  wire        HSYNC_I,
  input  wire        VRETRACE_I,
  input  wire        VIDEO_I,
  input  wire        VSYNC_I,
  input  wire        BUS_ALT_I,
  input  wire        IRQ_EN_I,
  input  wire        IRQ_ACTIVE_I,
  // sliding unit delay write path
  input  wire        CPU_WR_I,
  input  wire [1:0]  WR_MODE_I,
  input  wire [31:0] CPU_WDATA_I,
  output reg  [31:0] SLIDE_WDATA_O,
  output reg  [3:0]  STATUS1_BITS_O,
  output reg         IRQ_OUT_O,
  output reg         IRQ_OE_O,
  output reg  [6:0]  PROTECT_O,
  output reg         PROT_TIMING0_O,
  output reg         PAL_RD_STROBE_O,
  output reg         PAL_WR_STROBE_O,
  output reg         TRAP_O,
  output reg  [1:0]  EMU_MODE_O,
  output reg         ALT_TIMING_SEL_O,
  output reg  [7:0]  ALT_HTOTAL_O,
  output reg  [7:0]  ALT_HDISP_END_O,
  output reg  [7:0]  ALT_HBLANK_ST_O,
  output reg  [6:0]  ALT_HBLANK_END_O,
  output reg  [1:0]  ALT_DE_SKEW_O,
  output reg         ALT_SPLIT_ENH_O,
  output reg  [7:0]  ALT_HSYNC_ST_O,
  output reg  [4:0]  ALT_HSYNC_END_O,
  output reg  [1:0]  ALT_HSYNC_DLY_O,
  output reg  [7:0]  ALT_ROW_OFS_O,
  output reg  [5:0]  FORCE_LEVELS_O
);

  reg [7:0] emu_reg, prot_reg, trap_en_reg, trap_st_reg;
  reg [7:0] alt_hdisp_reg, alt_hss_reg, alt_hse_reg, alt_ht_reg;
  reg [7:0] alt_hbs_reg, alt_hbe_reg, alt_ofs_reg, slide_reg, force_reg;
  reg [7:0] hold_reg [0:3];
  reg [4:0] sync1_reg, sync2_reg;
  reg [1:0] irq_sync1_reg, irq_sync2_reg;
  reg [5:0] trap_hit;
  reg [7:0] rd_next;
  reg       sts_bit0, sts_bit3, sts_bit7;
  integer   p;

  // trap group decode of one observed access
  function [5:0] trap_groups;
    input       io_acc;
    input [9:0] addr;
    input       crtc_acc;
    input [4:0] cidx;
    begin
      trap_groups = 6'h00;
      if (io_acc) begin
        trap_groups[0] = (addr == 10'h3B4) || (addr == 10'h3B5);
        trap_groups[1] = (addr == 10'h3B8) || (addr == 10'h3BF);
        trap_groups[2] = (addr[9:4] == 6'h3C);
        trap_groups[3] = (addr == 10'h3D4) || (addr == 10'h3D5);
        trap_groups[4] = (addr == 10'h3D8) || (addr == 10'h3D9);
      end
      if (crtc_acc)
        trap_groups[5] = (cidx <= `CRTC_LAST_LOW) ||
                         ((cidx >= `CRTC_FIRST_HIGH) && (cidx <= `CRTC_LAST_HIGH));
    end
  endfunction

  // one plane's slide: shift by one unit and pull in carry-over from hold
  function [7:0] slide_byte;
    input [7:0] d;
    input [7:0] hold;
    input       right;
    begin
      if (right)
        slide_byte = {hold[0], d[7:1]};
      else
        slide_byte = {d[6:0], hold[7]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // status sources come from the video clock; two flops before use, except BUS_ALT_I, which is used directly
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1_reg     <= 5'h00;
      sync2_reg     <= 5'h00;
      irq_sync1_reg <= 2'h0;
      irq_sync2_reg <= 2'h0;
    end else begin
      sync1_reg     <= {VSYNC_I, VIDEO_I, VRETRACE_I, HSYNC_I, DISP_EN_I};
      sync2_reg     <= sync1_reg;
      irq_sync1_reg <= {IRQ_ACTIVE_I, IRQ_EN_I};
      irq_sync2_reg <= irq_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback mux and trap decode
  always @* begin
    trap_hit = trap_groups(IO_ACCESS_I, IO_ADDR_I, CRTC_ACCESS_I, CRTC_INDEX_I);
    case (EXT_INDEX_I)
      // config port readback in bits 3-2
      `IDX_EMU_MODE:       rd_next = {emu_reg[7:4], MONO_CFG_I, emu_reg[1:0]};
      `IDX_WR_PROTECT:     rd_next = prot_reg;
      `IDX_TRAP_ENABLE:    rd_next = trap_en_reg;
      `IDX_TRAP_STATUS:    rd_next = trap_st_reg;
      `IDX_ALT_HDISP_END:  rd_next = alt_hdisp_reg;
      `IDX_ALT_HSYNC_ST:   rd_next = alt_hss_reg;
      `IDX_ALT_HSYNC_END:  rd_next = alt_hse_reg;
      `IDX_ALT_HTOTAL:     rd_next = alt_ht_reg;
      `IDX_ALT_HBLANK_ST:  rd_next = alt_hbs_reg;
      `IDX_ALT_HBLANK_END: rd_next = alt_hbe_reg;
      `IDX_ALT_ROW_OFS:    rd_next = alt_ofs_reg;
      `IDX_SLIDE_CTRL:     rd_next = slide_reg;
      `IDX_HOLD_PLANE0:    rd_next = hold_reg[0];
      `IDX_HOLD_PLANE1:    rd_next = hold_reg[1];
      `IDX_HOLD_PLANE2:    rd_next = hold_reg[2];
      `IDX_HOLD_PLANE3:    rd_next = hold_reg[3];
      `IDX_FORCE_LEVELS:   rd_next = force_reg;
      default:             rd_next = `REG_RESET;
    endcase
    sts_bit0 = emu_reg[`EMU_DE_MODE_BIT] ? sync2_reg[1] : sync2_reg[0];
    sts_bit3 = emu_reg[`EMU_VR_MODE_BIT] ? sync2_reg[3] : sync2_reg[2];
    sts_bit7 = emu_reg[`EMU_VS_MODE_BIT] & sync2_reg[4];
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; masks keep reserved bits at zero
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      emu_reg       <= `REG_RESET;
      prot_reg      <= `REG_RESET;
      trap_en_reg   <= `REG_RESET;
      trap_st_reg   <= `REG_RESET;
      alt_hdisp_reg <= `REG_RESET;
      alt_hss_reg   <= `REG_RESET;
      alt_hse_reg   <= `REG_RESET;
      alt_ht_reg    <= `REG_RESET;
      alt_hbs_reg   <= `REG_RESET;
      alt_hbe_reg   <= `REG_RESET;
      alt_ofs_reg   <= `REG_RESET;
      slide_reg     <= `REG_RESET;
      force_reg     <= `REG_RESET;
      for (p = 0; p < 4; p = p + 1)
        hold_reg[p] <= `REG_RESET;
      EXT_RDATA_O   <= `REG_RESET;
    end else begin
      if (EXT_RD_I)
        EXT_RDATA_O <= rd_next;
      // read clears, a trap in the same cycle wins
      if (EXT_RD_I && (EXT_INDEX_I == `IDX_TRAP_STATUS))
        trap_st_reg <= {2'h0, trap_hit & trap_en_reg[5:0]};
      else
        trap_st_reg <= trap_st_reg | {2'h0, trap_hit & trap_en_reg[5:0]};
      if (EXT_WR_I) begin
        case (EXT_INDEX_I)
          // reserved and read-only bits are masked
          `IDX_EMU_MODE:       emu_reg       <= EXT_WDATA_I & `EMU_WR_MASK;
          `IDX_WR_PROTECT:     prot_reg      <= EXT_WDATA_I & `PROT_WR_MASK;
          `IDX_TRAP_ENABLE:    trap_en_reg   <= EXT_WDATA_I & `TRAP_WR_MASK;
          `IDX_ALT_HDISP_END:  alt_hdisp_reg <= EXT_WDATA_I;
          `IDX_ALT_HSYNC_ST:   alt_hss_reg   <= EXT_WDATA_I;
          `IDX_ALT_HSYNC_END:  alt_hse_reg   <= EXT_WDATA_I;
          `IDX_ALT_HTOTAL:     alt_ht_reg    <= EXT_WDATA_I;
          `IDX_ALT_HBLANK_ST:  alt_hbs_reg   <= EXT_WDATA_I;
          `IDX_ALT_HBLANK_END: alt_hbe_reg   <= EXT_WDATA_I;
          `IDX_ALT_ROW_OFS:    alt_ofs_reg   <= EXT_WDATA_I;
          `IDX_SLIDE_CTRL:     slide_reg     <= EXT_WDATA_I & `SLIDE_WR_MASK;
          `IDX_FORCE_LEVELS:   force_reg     <= EXT_WDATA_I & `FORCE_WR_MASK;
          default:             ;
        endcase
      end
      // carry-over capture; software writes take priority
      for (p = 0; p < 4; p = p + 1) begin
        if (EXT_WR_I && (EXT_INDEX_I == (`IDX_HOLD_PLANE0 + p[6:0])))
          hold_reg[p] <= EXT_WDATA_I;
        // plane 0 in modes 0, 2 and 3, planes 1-3 in mode 1
        else if (CPU_WR_I && slide_reg[`SLIDE_EN_BIT] &&
                 (((WR_MODE_I != 2'h1) && (p == 0)) || ((WR_MODE_I == 2'h1) && (p != 0))))
          hold_reg[p] <= CPU_WDATA_I[p*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SLIDE_WDATA_O    <= 32'h00000000;
      STATUS1_BITS_O   <= 4'h0;
      IRQ_OUT_O        <= 1'b0;
      IRQ_OE_O         <= 1'b0;
      PROTECT_O        <= 7'h00;
      PROT_TIMING0_O   <= 1'b0;
      PAL_RD_STROBE_O  <= 1'b0;
      PAL_WR_STROBE_O  <= 1'b0;
      TRAP_O           <= 1'b0;
      EMU_MODE_O       <= `EMU_STD;
      ALT_TIMING_SEL_O <= 1'b0;
      ALT_HTOTAL_O     <= 8'h00;
      ALT_HDISP_END_O  <= 8'h00;
      ALT_HBLANK_ST_O  <= 8'h00;
      ALT_HBLANK_END_O <= 7'h00;
      ALT_DE_SKEW_O    <= 2'h0;
      ALT_SPLIT_ENH_O  <= 1'b0;
      ALT_HSYNC_ST_O   <= 8'h00;
      ALT_HSYNC_END_O  <= 5'h00;
      ALT_HSYNC_DLY_O  <= 2'h0;
      ALT_ROW_OFS_O    <= 8'h00;
      FORCE_LEVELS_O   <= 6'h00;
    end else begin
      // sliding merge before rotate/logic op downstream
      for (p = 0; p < 4; p = p + 1) begin
        if (slide_reg[`SLIDE_EN_BIT])
          SLIDE_WDATA_O[p*8 +: 8] <= slide_byte(CPU_WDATA_I[p*8 +: 8],
                                       (WR_MODE_I == 2'h1) ? hold_reg[p] : hold_reg[0],
                                       slide_reg[`SLIDE_DIR_BIT]);
        else
          SLIDE_WDATA_O[p*8 +: 8] <= CPU_WDATA_I[p*8 +: 8];
      end
      // order: bit7, bit3, unused slot zero, bit0
      STATUS1_BITS_O <= {sts_bit7, sts_bit3, 1'b0, sts_bit0};
      if (!emu_reg[`EMU_IRQ_FN_BIT]) begin
        IRQ_OE_O  <= BUS_ALT_I & irq_sync2_reg[0] & irq_sync2_reg[1];
        IRQ_OUT_O <= 1'b0;
      end else begin
        IRQ_OE_O  <= ~BUS_ALT_I & irq_sync2_reg[0];
        IRQ_OUT_O <= irq_sync2_reg[1];
      end
      PROTECT_O <= prot_reg[6:0];
      // auxiliary protect ORed with the timing controller's own bit
      PROT_TIMING0_O <= prot_reg[`PROT_TIMING0_GRP] | CRTC_PROTECT_I;
      PAL_RD_STROBE_O <= PAL_RD_REQ_I & ~prot_reg[`PROT_PAL_GRP];
      PAL_WR_STROBE_O <= PAL_WR_REQ_I & ~prot_reg[`PROT_PAL_GRP];
      // trap output on enabled group hit
      TRAP_O <= |(trap_hit & trap_en_reg[5:0]);
      EMU_MODE_O <= emu_reg[1:0];
      // alternate timing in colour-gfx and mono-gfx emulation
      ALT_TIMING_SEL_O <= (emu_reg[1:0] == `EMU_COLOR_GFX) ||
                          (emu_reg[1:0] == `EMU_MONO_GFX);
      ALT_HTOTAL_O    <= alt_ht_reg;
      ALT_HDISP_END_O <= alt_hdisp_reg;
      ALT_HBLANK_ST_O <= alt_hbs_reg;
      // blank end bit 5 lives in sync end bit 7
      ALT_HBLANK_END_O <= {1'b0, alt_hse_reg[7], alt_hbe_reg[4:0]};
      ALT_DE_SKEW_O    <= alt_hbe_reg[6:5];
      ALT_SPLIT_ENH_O <= alt_hbe_reg[`ALT_BLANK_MODE_BIT];
      ALT_HSYNC_ST_O  <= alt_hss_reg;
      ALT_HSYNC_END_O <= alt_hse_reg[4:0];
      ALT_HSYNC_DLY_O <= alt_hse_reg[6:5];
      ALT_ROW_OFS_O   <= alt_ofs_reg;
      FORCE_LEVELS_O <= force_reg[5:0];
    end
  end

endmodule

// File: bench/ext_ctrl_checker.sv
// assertion checker for the extension control register bank
`timescale 1ns/1ps
`include "ext_ctrl_map.vh"
module ext_ctrl_checker (
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_I,
  input wire logic [6:0] EXT_INDEX_I,
  input wire logic       EXT_WR_I,
  input wire logic       EXT_RD_I,
  input wire logic [7:0] EXT_RDATA_O,
  input wire logic       IO_ACCESS_I,
  input wire logic       CRTC_ACCESS_I,
  input wire logic       PAL_WR_REQ_I,
  input wire logic       CRTC_PROTECT_I,
  input wire logic [3:0] STATUS1_BITS_O,
  input wire logic [6:0] PROTECT_O,
  input wire logic       PROT_TIMING0_O,
  input wire logic       PAL_WR_STROBE_O,
  input wire logic       TRAP_O,
  input wire logic [1:0] EMU_MODE_O,
  input wire logic       ALT_TIMING_SEL_O,
  input wire logic [5:0] FORCE_LEVELS_O
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  trap_cause_a: assert property (TRAP_O |-> $past(IO_ACCESS_I) || $past(CRTC_ACCESS_I))
    else $error("trap pulse without an access");
  // guard the first edge after reset, when $past still sees reset-time inputs
  prot_or_a: assert property (!$past(RESET_I) |-> PROT_TIMING0_O == (PROTECT_O[6] | $past(CRTC_PROTECT_I)))
    else $error("timing protect is not the or of both bits");
  pal_gate_a: assert property (!$past(RESET_I) |-> PAL_WR_STROBE_O == ($past(PAL_WR_REQ_I) && !PROTECT_O[5]))
    else $error("palette strobe gating wrong");
  alt_sel_a: assert property (ALT_TIMING_SEL_O == (EMU_MODE_O == `EMU_COLOR_GFX || EMU_MODE_O == `EMU_MONO_GFX))
    else $error("alternate timing select wrong");
  status_gap_a: assert property (STATUS1_BITS_O[1] == 1'b0)
    else $error("unused status bit set");
  reset_clear_a: assert property ($fell(RESET_I) |-> !TRAP_O && FORCE_LEVELS_O == 6'h00 && PROTECT_O == 7'h00)
    else $error("outputs not clear after reset");
  rdata_hold_a: assert property (!$past(EXT_RD_I) |-> $stable(EXT_RDATA_O))
    else $error("read data moved without a read");
  force_src_a: assert property ($changed(FORCE_LEVELS_O) |-> $past(EXT_WR_I, 2) && $past(EXT_INDEX_I, 2) == `IDX_FORCE_LEVELS)
    else $error("force levels changed without a write");
endmodule
bind display_ext_control_regs ext_ctrl_checker ext_ctrl_checker_inst (.CORE_CLK_I, .RESET_I,
  .EXT_INDEX_I, .EXT_WR_I, .EXT_RD_I, .EXT_RDATA_O, .IO_ACCESS_I, .CRTC_ACCESS_I, .PAL_WR_REQ_I,
  .CRTC_PROTECT_I, .STATUS1_BITS_O, .PROTECT_O, .PROT_TIMING0_O, .PAL_WR_STROBE_O, .TRAP_O,
  .EMU_MODE_O, .ALT_TIMING_SEL_O, .FORCE_LEVELS_O);

// File: bench/host_io_model.sv
// host model issuing indexed extension register accesses
`timescale 1ns/1ps
module host_io_model (
  input  wire logic  clk_i,
  output logic [6:0] idx_o,
  output logic       wr_o,
  output logic       rd_o,
  output logic [7:0] wdata_o
);
  // idle bus at time zero
  initial begin
    {idx_o, wr_o, rd_o, wdata_o} = 17'h0;
  end
  // one-cycle strobe; data scrambled once released so stale values never match
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    @(negedge clk_i);
    idx_o = i;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [6:0] i);
    @(negedge clk_i);
    idx_o = i;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
  endtask
endmodule

// File: bench/test_display_ext_control_regs.sv
// self-checking bench for the extension control register bank
`timescale 1ns/1ps
module test_display_ext_control_regs;
  logic        CORE_CLK_I, RESET_I, EXT_WR_I, EXT_RD_I, IO_ACCESS_I, CRTC_ACCESS_I, CPU_WR_I;
  logic        PAL_RD_REQ_I, PAL_WR_REQ_I, CRTC_PROTECT_I, DISP_EN_I, HSYNC_I, VRETRACE_I;
  logic        VIDEO_I, VSYNC_I, BUS_ALT_I, IRQ_EN_I, IRQ_ACTIVE_I, TRAP_O, IRQ_OUT_O, IRQ_OE_O;
  logic        PROT_TIMING0_O, PAL_RD_STROBE_O, PAL_WR_STROBE_O, ALT_TIMING_SEL_O, ALT_SPLIT_ENH_O;
  logic [1:0]  MONO_CFG_I, WR_MODE_I, EMU_MODE_O, ALT_DE_SKEW_O, ALT_HSYNC_DLY_O;
  logic [4:0]  CRTC_INDEX_I, ALT_HSYNC_END_O;
  logic [6:0]  EXT_INDEX_I, PROTECT_O, ALT_HBLANK_END_O;
  logic [7:0]  EXT_WDATA_I, EXT_RDATA_O, ALT_HTOTAL_O, ALT_HDISP_END_O, ALT_HBLANK_ST_O;
  logic [7:0]  ALT_HSYNC_ST_O, ALT_ROW_OFS_O, exp_q[$], val_t[16];
  logic [3:0]  STATUS1_BITS_O;
  logic [5:0]  FORCE_LEVELS_O;
  logic [9:0]  IO_ADDR_I;
  logic [31:0] CPU_WDATA_I, SLIDE_WDATA_O, d, h;
  logic        rd_d1, rd_d2;
  int          err_count, checked, trap_cnt, pal_cnt, t0, n;
  integer      seed;
  logic [6:0]  idx_t[16] = '{7'h14, 7'h15, 7'h16, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D,
                             7'h1E, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h27};
  logic [7:0]  msk_t[16] = '{8'hF3, 8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                             8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F};
  logic [9:0]  adr_t[6] = '{10'h3B5, 10'h3BF, 10'h3C0, 10'h3D5, 10'h3D9, 10'h000};
  display_ext_control_regs display_ext_control_regs_inst (.CORE_CLK_I, .RESET_I, .EXT_INDEX_I,
    .EXT_WR_I, .EXT_RD_I, .EXT_WDATA_I, .EXT_RDATA_O, .IO_ACCESS_I, .IO_ADDR_I, .CRTC_ACCESS_I,
    .CRTC_INDEX_I, .PAL_RD_REQ_I, .PAL_WR_REQ_I, .CRTC_PROTECT_I, .MONO_CFG_I, .DISP_EN_I,
    .HSYNC_I, .VRETRACE_I, .VIDEO_I, .VSYNC_I, .BUS_ALT_I, .IRQ_EN_I, .IRQ_ACTIVE_I, .CPU_WR_I,
    .WR_MODE_I, .CPU_WDATA_I, .SLIDE_WDATA_O, .STATUS1_BITS_O, .IRQ_OUT_O, .IRQ_OE_O, .PROTECT_O,
    .PROT_TIMING0_O, .PAL_RD_STROBE_O, .PAL_WR_STROBE_O, .TRAP_O, .EMU_MODE_O, .ALT_TIMING_SEL_O,
    .ALT_HTOTAL_O, .ALT_HDISP_END_O, .ALT_HBLANK_ST_O, .ALT_HBLANK_END_O, .ALT_DE_SKEW_O,
    .ALT_SPLIT_ENH_O, .ALT_HSYNC_ST_O, .ALT_HSYNC_END_O, .ALT_HSYNC_DLY_O, .ALT_ROW_OFS_O,
    .FORCE_LEVELS_O);
  host_io_model host_io_model_inst (.clk_i(CORE_CLK_I), .idx_o(EXT_INDEX_I), .wr_o(EXT_WR_I),
    .rd_o(EXT_RD_I), .wdata_o(EXT_WDATA_I));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic w(input logic [6:0] i, input logic [7:0] v);
    host_io_model_inst.wr(i, v);
  endtask
  // expectation is queued before the read goes out
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    host_io_model_inst.rd(i);
  endtask
  task automatic acc(input logic io, input logic [9:0] a, input logic [4:0] c);
    @(negedge CORE_CLK_I);
    {IO_ACCESS_I, CRTC_ACCESS_I, IO_ADDR_I, CRTC_INDEX_I} = {io, !io, a, c};
    @(negedge CORE_CLK_I);
    {IO_ACCESS_I, CRTC_ACCESS_I} = 2'h0;
  endtask
  task automatic cpuw(input logic [1:0] m, input logic [31:0] dd, e, k);
    @(negedge CORE_CLK_I);
    {CPU_WR_I, WR_MODE_I, CPU_WDATA_I} = {1'b1, m, dd};
    @(negedge CORE_CLK_I);
    CPU_WR_I = 1'b0;
    check(SLIDE_WDATA_O & k, e & k);
  endtask
  // one bit slides per plane: left pulls hold bit 7, right pulls hold bit 0
  function automatic logic [31:0] slid(input logic [31:0] dd, hh, input logic r);
    for (int p = 0; p < 32; p += 8)
      slid[p +: 8] = r ? {hh[p], dd[p+1 +: 7]} : {dd[p +: 7], hh[p+7]};
  endfunction
  task automatic print_verdict;
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // clock and a random timing protect level
  initial begin
    CORE_CLK_I = 1'b0;
    forever #4 CORE_CLK_I = ~CORE_CLK_I;
  end
  always @(negedge CORE_CLK_I) CRTC_PROTECT_I <= $random(seed);
  // result watcher: read data is checked two edges after the edge that samples the read strobe
  always @(posedge CORE_CLK_I) begin
    rd_d1 <= EXT_RD_I;
    rd_d2 <= rd_d1;
    if (rd_d2 === 1'b1) check(EXT_RDATA_O, exp_q.pop_front());
    if (TRAP_O === 1'b1) trap_cnt++;
    if (PAL_WR_STROBE_O === 1'b1 && PAL_RD_STROBE_O === 1'b1) pal_cnt++;
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    seed = 32'h45fde392;
    {RESET_I, IO_ACCESS_I, CRTC_ACCESS_I, PAL_RD_REQ_I, PAL_WR_REQ_I, CPU_WR_I} = 6'h20;
    {DISP_EN_I, HSYNC_I, VRETRACE_I, VIDEO_I, VSYNC_I, BUS_ALT_I, IRQ_EN_I, IRQ_ACTIVE_I} = 8'h0;
    {IO_ADDR_I, CRTC_INDEX_I, CRTC_PROTECT_I, WR_MODE_I, CPU_WDATA_I, rd_d1, rd_d2} = 0;
    MONO_CFG_I = $random(seed);
    {err_count, checked, trap_cnt, pal_cnt} = 0;
    repeat (6) @(negedge CORE_CLK_I);
    RESET_I = 1'b0;
    for (int i = 0; i < 16; i++) rd(idx_t[i], i ? 8'h00 : {4'h0, MONO_CFG_I, 2'h0});
    for (int i = 0; i < 16; i++) begin
      val_t[i] = $random(seed);
      w(idx_t[i], val_t[i]);
      rd(idx_t[i], val_t[i] & msk_t[i] | (i ? 8'h00 : {4'h0, MONO_CFG_I, 2'h0}));
    end
    w(7'h25, 8'hFF);
    rd(7'h25, 8'h00);
    rd(7'h17, 8'h00);
    check(FORCE_LEVELS_O, val_t[15][5:0]);
    check(PROTECT_O, val_t[1][6:0]);
    check(ALT_HTOTAL_O, val_t[6]);
    check(ALT_SPLIT_ENH_O, val_t[8][7]);
    check(ALT_HBLANK_END_O, {1'b0, val_t[5][7], val_t[8][4:0]});
    check(ALT_HSYNC_DLY_O, val_t[5][6:5]);
    check(ALT_HDISP_END_O, val_t[3]);
    check(ALT_HSYNC_ST_O, val_t[4]);
    check(ALT_HSYNC_END_O, val_t[5][4:0]);
    check(ALT_HBLANK_ST_O, val_t[7]);
    check(ALT_DE_SKEW_O, val_t[8][6:5]);
    check(ALT_ROW_OFS_O, val_t[9]);
    for (int m = 0; m < 4; m++) begin
      w(7'h14, m[7:0]);
      @(negedge CORE_CLK_I);
      check(EMU_MODE_O, m);
      check(ALT_TIMING_SEL_O, m[0]);
    end
    {DISP_EN_I, HSYNC_I, VRETRACE_I, VIDEO_I, VSYNC_I} = 5'b10101;
    repeat (5) @(negedge CORE_CLK_I);
    check(STATUS1_BITS_O, 4'b0101);
    w(7'h14, 8'h70);
    repeat (5) @(negedge CORE_CLK_I);
    check(STATUS1_BITS_O, 4'b1000);
    for (int k = 0; k < 16; k++) begin
      w(7'h14, {k[3], 7'h00});
      {BUS_ALT_I, IRQ_EN_I, IRQ_ACTIVE_I} = k[2:0];
      repeat (5) @(negedge CORE_CLK_I);
      check(IRQ_OE_O, k[3] ? (!k[2] && k[1]) : (k[2] && k[1] && k[0]));
      if (IRQ_OE_O === 1'b1) check(IRQ_OUT_O, k[3] && k[0]);
    end
    for (int g = 0; g < 6; g++) begin
      t0 = trap_cnt;
      n = (g + 1) % 6;
      w(7'h16, 8'h01 << g);
      acc(g != 5, adr_t[g], 5'h0B);
      acc(n != 5, adr_t[n], 5'h00);
      rd(7'h17, 8'h01 << g);
      rd(7'h17, 8'h00);
      check(trap_cnt - t0, 1);
    end
    for (int p = 0; p < 2; p++) begin
      w(7'h15, {2'h0, p[0], 5'h00});
      t0 = pal_cnt;
      @(negedge CORE_CLK_I);
      {PAL_RD_REQ_I, PAL_WR_REQ_I} = 2'h3;
      @(negedge CORE_CLK_I);
      {PAL_RD_REQ_I, PAL_WR_REQ_I} = 2'h0;
      repeat (2) @(negedge CORE_CLK_I);
      check(pal_cnt - t0, !p);
    end
    d = $random(seed);
    w(7'h20, 8'h02);
    cpuw(2'h0, d, d, 32'hFFFFFFFF);
    w(7'h20, 8'h01);
    w(7'h21, 8'h80);
    cpuw(2'h0, d, slid(d, {4{8'h80}}, 1'b0), 32'hFFFFFFFF);
    h = $random(seed);
    cpuw(2'h3, h, slid(h, {4{d[7:0]}}, 1'b0), 32'hFFFFFFFF);
    rd(7'h21, h[7:0]);
    w(7'h20, 8'h03);
    for (int p = 1; p < 4; p++) w(7'h21 + p, h[p*8 +: 8]);
    d = $random(seed);
    cpuw(2'h1, d, slid(d, h, 1'b1), 32'hFFFFFF00);
    rd(7'h22, d[15:8]);
    repeat (4) @(negedge CORE_CLK_I);
    print_verdict();
  end
endmodule
